// ===== hw/fbp_consts.vh
// Constants for the flash boot and program control block
`ifndef FBP_CONSTS_VH
`define FBP_CONSTS_VH

// Register byte offsets
`define FBP_OFS_FLMODE    8'h00
`define FBP_OFS_BLKSEL1   8'h04
`define FBP_OFS_BLKSEL2   8'h08
`define FBP_OFS_SERCTRL   8'h0C
`define FBP_OFS_BAUD      8'h10
`define FBP_OFS_PORTDIR   8'h14
`define FBP_OFS_PORTDATA  8'h18
`define FBP_OFS_BOOTCTRL  8'h1C
`define FBP_OFS_STATUS    8'h20
`define FBP_OFS_LATADDR   8'h24
`define FBP_OFS_LATDATA   8'h28

// Flash mode control bits
`define FBP_FL_PROG       0
`define FBP_FL_ERASE      1
`define FBP_FL_PVER       2
`define FBP_FL_EVER       3
`define FBP_FL_HV         6
`define FBP_FL_MASK       8'h4F

// Serial control and port bits
`define FBP_SER_RX_EN     4
`define FBP_SER_TX_EN     5
`define FBP_SER_MASK      8'hFF
`define FBP_TX_PORT_BIT   1

// Boot control bits
`define FBP_BC_DL_DONE    0
`define FBP_BC_WDT_RSTOUT 1

// Reset and erased values
`define FBP_RST_BAUD      8'hFF
`define FBP_ERASED_BYTE   8'hFF

// Timing and sizes
`define FBP_READY_STATES  100
`define FBP_READY_CYC     (`FBP_READY_STATES)
`define FBP_LOW_BITS      9
`define FBP_BAUD_OVS      32
`define FBP_MEAS_DIV      20'h00120
`define FBP_FLASH_AW      17
`define FBP_FLASH_LAST    17'h1FFFF
`define FBP_USER_ENTRY    16'hF300

`endif

// ===== hw/fbp_sync.v
// Two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module fbp_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Data
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= d[i];
          sync_reg <= meta_reg;
        end
      end
      assign q[i] = sync_reg;
    end
  endgenerate
endmodule // fbp_sync

// ===== hw/fbp_ctrl.v
// Flash boot and on-board program control with APB register slave
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "fbp_consts.vh"
module fbp_ctrl (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Mode pins, asynchronous
  input  wire        vpp_hv_pin,
  input  wire        upper_mode_pin,
  input  wire [1:0]  mode_lo_pins,
  // Watchdog
  input  wire        wdt_ovf,
  output reg         wdt_rst_out,
  // Serial channel one
  input  wire        boot_serial_rx_pin,
  output reg         boot_serial_tx_pin,
  output reg         boot_serial_tx_oe,
  output reg         sci_tx_en,
  output reg         sci_rx_en,
  output reg  [7:0]  sci_baud_div,
  // Flash array
  output reg  [16:0] scan_addr,
  input  wire [7:0]  scan_rdata,
  output reg         erase_all_req,
  input  wire        erase_done,
  input  wire        erase_fail,
  input  wire        cpu_fl_wr,
  input  wire [16:0] cpu_fl_addr,
  input  wire [7:0]  cpu_fl_wdata,
  output reg  [16:0] fl_latch_addr,
  output reg  [7:0]  fl_latch_data,
  output reg         prog_pulse,
  output reg         erase_pulse,
  output reg         pverify,
  output reg         everify,
  output reg         prewrite_verify,
  output reg  [7:0]  blk_sel1,
  output reg  [7:0]  blk_sel2,
  output reg         flash_rd_ok,
  output reg         irq_inhibit,
  // Mode and hand-off
  output reg         boot_mode,
  output reg         user_prog_mode,
  output reg         jump_req,
  output reg  [15:0] jump_addr
);

  localparam ST_IDLE  = 4'h0;
  localparam ST_READY = 4'h1;
  localparam ST_RXHI  = 4'h2;
  localparam ST_MEAS  = 4'h3;
  localparam ST_SCAN  = 4'h4;
  localparam ST_ERASE = 4'h5;
  localparam ST_DLOAD = 4'h6;
  localparam ST_JUMP  = 4'h7;
  localparam ST_USER  = 4'h8;
  localparam ST_HALT  = 4'h9;

  wire [4:0]  pins_s;
  wire        vpp_hv_s  = pins_s[0];
  wire        md2_hv_s  = pins_s[1];
  wire [1:0]  md_lo_s   = pins_s[3:2];
  wire        rx_s      = pins_s[4];

  fbp_sync #(.W(5)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({boot_serial_rx_pin, mode_lo_pins, upper_mode_pin, vpp_hv_pin}),
    .q       (pins_s)
  );

  reg  [7:0]  flash_mode_ctrl_reg;
  reg  [7:0]  block_sel_reg_1;
  reg  [7:0]  block_sel_reg_2;
  reg  [7:0]  serial_ctrl_reg;
  reg  [7:0]  baud_divisor_reg;
  reg  [7:0]  port_dir_reg;
  reg  [7:0]  port_data_reg;
  reg         wdt_rst_out_bit_reg;
  reg  [1:0]  cap_cnt_reg;
  reg         boot_latched_reg;
  reg  [3:0]  state_reg;
  reg  [19:0] cnt_reg;
  reg         scan_valid_reg;
  reg         dirty_reg;
  reg         erase_err_reg;
  reg  [16:0] cmp_addr_reg;

  // APB: one wait state, so every answer comes from a flop
  wire apb_acc = psel & penable & ~pready;
  wire apb_wr  = psel & penable & pready & pwrite;

  reg        hit;
  reg [31:0] rd_mux;
  always @* begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == `FBP_OFS_FLMODE) begin
      rd_mux[7:0] = flash_mode_ctrl_reg;
    end else if (paddr == `FBP_OFS_BLKSEL1) begin
      rd_mux[7:0] = block_sel_reg_1;
    end else if (paddr == `FBP_OFS_BLKSEL2) begin
      rd_mux[7:0] = block_sel_reg_2;
    end else if (paddr == `FBP_OFS_SERCTRL) begin
      rd_mux[7:0] = serial_ctrl_reg;
    end else if (paddr == `FBP_OFS_BAUD) begin
      rd_mux[7:0] = baud_divisor_reg;
    end else if (paddr == `FBP_OFS_PORTDIR) begin
      rd_mux[7:0] = port_dir_reg;
    end else if (paddr == `FBP_OFS_PORTDATA) begin
      rd_mux[7:0] = port_data_reg;
    end else if (paddr == `FBP_OFS_BOOTCTRL) begin
      rd_mux[`FBP_BC_WDT_RSTOUT] = wdt_rst_out_bit_reg;
    end else if (paddr == `FBP_OFS_STATUS) begin
      rd_mux[0]    = boot_latched_reg;
      rd_mux[1]    = user_prog_mode;
      rd_mux[2]    = ~flash_rd_ok;
      rd_mux[3]    = dirty_reg;
      rd_mux[4]    = erase_err_reg;
      rd_mux[5]    = vpp_hv_s;
      rd_mux[11:8] = state_reg;
    end else if (paddr == `FBP_OFS_LATADDR) begin
      rd_mux[16:0] = fl_latch_addr;
    end else if (paddr == `FBP_OFS_LATDATA) begin
      rd_mux[7:0] = fl_latch_data;
    end else begin
      hit = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc & ~hit;
      prdata  <= (apb_acc & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  wire wr_fl   = apb_wr & (paddr == `FBP_OFS_FLMODE);
  wire wr_b1   = apb_wr & (paddr == `FBP_OFS_BLKSEL1);
  wire wr_b2   = apb_wr & (paddr == `FBP_OFS_BLKSEL2);
  wire wr_ser  = apb_wr & (paddr == `FBP_OFS_SERCTRL);
  wire wr_baud = apb_wr & (paddr == `FBP_OFS_BAUD);
  wire wr_dir  = apb_wr & (paddr == `FBP_OFS_PORTDIR);
  wire wr_dat  = apb_wr & (paddr == `FBP_OFS_PORTDATA);
  wire wr_bc   = apb_wr & (paddr == `FBP_OFS_BOOTCTRL);
  wire dl_done = wr_bc & pwdata[`FBP_BC_DL_DONE];

  // Mode decode from the synchronised pins
  wire rom_mode  = (md_lo_s != 2'b00);
  wire boot_pins = vpp_hv_s & md2_hv_s & rom_mode;
  wire boot_wdt  = wdt_ovf & boot_latched_reg;

  // Strap caught after the synchronisers have filled, never at reset itself
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_cnt_reg      <= 2'b00;
      boot_latched_reg <= 1'b0;
    end else if (cap_cnt_reg != 2'b11) begin
      cap_cnt_reg <= cap_cnt_reg + 2'b01;
      if (cap_cnt_reg == 2'b10) begin
        boot_latched_reg <= boot_pins;
      end
    end
  end

  // Low period of nine bits divided down to the baud divisor
  wire [19:0] div_full = cnt_reg / `FBP_MEAS_DIV;
  wire [7:0]  div_meas = (div_full == 20'h00000) ? 8'h00 :
                         (div_full > 20'h00100)  ? 8'hFF : div_full[7:0] - 8'h01;

  // Boot sequencer and register file
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg           <= ST_IDLE;
      cnt_reg             <= 20'h00000;
      scan_addr           <= 17'h00000;
      cmp_addr_reg        <= 17'h00000;
      scan_valid_reg      <= 1'b0;
      dirty_reg           <= 1'b0;
      erase_err_reg       <= 1'b0;
      erase_all_req       <= 1'b0;
      jump_req            <= 1'b0;
      jump_addr           <= 16'h0000;
      flash_mode_ctrl_reg <= 8'h00;
      block_sel_reg_1     <= 8'h00;
      block_sel_reg_2     <= 8'h00;
      serial_ctrl_reg     <= 8'h00;
      baud_divisor_reg    <= `FBP_RST_BAUD;
      port_dir_reg        <= 8'h00;
      port_data_reg       <= 8'h00;
      wdt_rst_out_bit_reg <= 1'b0;
    end else begin
      jump_req <= 1'b0;
      if (wr_fl)   flash_mode_ctrl_reg <= pwdata[7:0] & `FBP_FL_MASK;
      if (wr_b1)   block_sel_reg_1 <= pwdata[7:0];
      if (wr_b2)   block_sel_reg_2 <= pwdata[7:0];
      if (wr_ser)  serial_ctrl_reg <= pwdata[7:0] & `FBP_SER_MASK;
      if (wr_baud) baud_divisor_reg <= pwdata[7:0];
      if (wr_dir)  port_dir_reg <= pwdata[7:0];
      if (wr_dat)  port_data_reg <= pwdata[7:0];
      if (wr_bc)   wdt_rst_out_bit_reg <= pwdata[`FBP_BC_WDT_RSTOUT];
      if (wdt_ovf) begin
        // A watchdog reset also ends any program or erase in flight
        flash_mode_ctrl_reg <= 8'h00;
      end
      if (boot_wdt) begin
        state_reg      <= ST_READY;
        cnt_reg        <= 20'h00000;
        erase_all_req  <= 1'b0;
        scan_valid_reg <= 1'b0;
        dirty_reg      <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (cap_cnt_reg == 2'b11) begin
              state_reg <= boot_latched_reg ? ST_READY : ST_USER;
            end
          end
          ST_READY: begin
            cnt_reg <= cnt_reg + 20'h00001;
            if (cnt_reg == `FBP_READY_CYC - 1) begin
              cnt_reg   <= 20'h00000;
              state_reg <= ST_RXHI;
            end
          end
          ST_RXHI: begin
            if (rx_s) begin
              state_reg <= ST_MEAS;
            end
          end
          ST_MEAS: begin
            if (!rx_s && cnt_reg != 20'hFFFFF) begin
              cnt_reg <= cnt_reg + 20'h00001;
            end else if (rx_s && cnt_reg != 20'h00000) begin
              baud_divisor_reg <= div_meas;
              serial_ctrl_reg[`FBP_SER_RX_EN] <= 1'b1;
              serial_ctrl_reg[`FBP_SER_TX_EN] <= 1'b1;
              cnt_reg          <= 20'h00000;
              scan_addr        <= 17'h00000;
              state_reg        <= ST_SCAN;
            end
          end
          ST_SCAN: begin
            // Read data lags the address by one cycle
            scan_valid_reg <= 1'b1;
            cmp_addr_reg   <= scan_addr;
            if (scan_addr != `FBP_FLASH_LAST) begin
              scan_addr <= scan_addr + 17'h00001;
            end
            // First programmed byte decides, so the rest need not be read
            if (scan_valid_reg && scan_rdata != `FBP_ERASED_BYTE) begin
              dirty_reg      <= 1'b1;
              scan_valid_reg <= 1'b0;
              erase_all_req  <= 1'b1;
              state_reg      <= ST_ERASE;
            end else if (scan_valid_reg && cmp_addr_reg == `FBP_FLASH_LAST) begin
              scan_valid_reg <= 1'b0;
              state_reg      <= ST_DLOAD;
            end
          end
          ST_ERASE: begin
            if (erase_fail) begin
              erase_all_req <= 1'b0;
              erase_err_reg <= 1'b1;
              state_reg     <= ST_HALT;
            end else if (erase_done) begin
              erase_all_req <= 1'b0;
              dirty_reg     <= 1'b0;
              state_reg     <= ST_DLOAD;
            end
          end
          ST_DLOAD: begin
            if (dl_done) begin
              state_reg <= ST_JUMP;
            end
          end
          ST_JUMP: begin
            serial_ctrl_reg[`FBP_SER_RX_EN] <= 1'b0;
            serial_ctrl_reg[`FBP_SER_TX_EN] <= 1'b0;
            port_dir_reg[`FBP_TX_PORT_BIT]  <= 1'b1;
            port_data_reg[`FBP_TX_PORT_BIT] <= 1'b1;
            jump_addr <= `FBP_USER_ENTRY;
            jump_req  <= 1'b1;
            state_reg <= ST_USER;
          end
          ST_USER: begin
            state_reg <= ST_USER;
          end
          default: begin
            state_reg <= ST_HALT;
          end
        endcase
      end
    end
  end

  // Flash operation decode, gated by the high voltage enable except pre-write verify, which needs the register clear, Vpp high and a ROM mode
  wire [7:0] fm      = flash_mode_ctrl_reg;
  wire hv_ok         = fm[`FBP_FL_HV] & vpp_hv_s;
  wire prog_nx       = hv_ok & fm[`FBP_FL_PROG];
  wire erase_nx      = hv_ok & fm[`FBP_FL_ERASE] & ~fm[`FBP_FL_PROG];
  wire pver_nx       = hv_ok & fm[`FBP_FL_PVER] & ~fm[`FBP_FL_PROG] & ~fm[`FBP_FL_ERASE];
  wire ever_nx       = hv_ok & fm[`FBP_FL_EVER] & ~fm[`FBP_FL_PROG] & ~fm[`FBP_FL_ERASE]
                       & ~fm[`FBP_FL_PVER];
  wire prewr_nx      = (fm == 8'h00) & vpp_hv_s & rom_mode;
  wire busy_nx       = prog_nx | erase_nx | erase_all_req;
  wire setup_wr      = cpu_fl_wr & hv_ok & ~fm[`FBP_FL_PROG] & ~fm[`FBP_FL_ERASE];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_pulse         <= 1'b0;
      erase_pulse        <= 1'b0;
      pverify            <= 1'b0;
      everify            <= 1'b0;
      prewrite_verify    <= 1'b0;
      flash_rd_ok        <= 1'b1;
      irq_inhibit        <= 1'b0;
      fl_latch_addr      <= 17'h00000;
      fl_latch_data      <= 8'h00;
      blk_sel1           <= 8'h00;
      blk_sel2           <= 8'h00;
      wdt_rst_out        <= 1'b0;
      boot_mode          <= 1'b0;
      user_prog_mode     <= 1'b0;
      sci_tx_en          <= 1'b0;
      sci_rx_en          <= 1'b0;
      sci_baud_div       <= `FBP_RST_BAUD;
      boot_serial_tx_pin <= 1'b0;
      boot_serial_tx_oe  <= 1'b0;
    end else begin
      prog_pulse      <= prog_nx;
      erase_pulse     <= erase_nx;
      pverify         <= pver_nx;
      everify         <= ever_nx;
      prewrite_verify <= prewr_nx;
      flash_rd_ok     <= ~busy_nx;
      irq_inhibit     <= busy_nx;
      if (setup_wr) begin
        fl_latch_addr <= cpu_fl_addr;
        fl_latch_data <= cpu_fl_wdata;
      end
      blk_sel1       <= block_sel_reg_1;
      blk_sel2       <= block_sel_reg_2;
      // Holding the reset output low under high voltage avoids a pin reset mid-program
      wdt_rst_out    <= wdt_ovf & wdt_rst_out_bit_reg & ~vpp_hv_s;
      boot_mode      <= boot_latched_reg;
      user_prog_mode <= ~boot_latched_reg & rom_mode & vpp_hv_s;
      sci_tx_en      <= serial_ctrl_reg[`FBP_SER_TX_EN];
      sci_rx_en      <= serial_ctrl_reg[`FBP_SER_RX_EN];
      sci_baud_div   <= baud_divisor_reg;
      boot_serial_tx_pin <= port_data_reg[`FBP_TX_PORT_BIT];
      boot_serial_tx_oe  <= port_dir_reg[`FBP_TX_PORT_BIT];
    end
  end

endmodule // fbp_ctrl

// ===== dv/fbp_host_model.sv
// Host stand-in on the boot serial line: sends zero bytes on request
`timescale 1ns/1ps
module fbp_host_model #(
  parameter int BIT = 80
) (
  input  wire logic pclk,
  input  wire logic send_byte,
  output logic      rx_line
);
  int cnt = 0;
  // Pulled-up line, so idle is high, also across reset release
  initial rx_line = 1'b1;
  // Start bit and eight zero bits give nine low bit times
  always @(posedge pclk) begin
    if (send_byte && cnt == 0)
      cnt <= 10 * BIT;
    else if (cnt != 0)
      cnt <= cnt - 1;
    rx_line <= !(cnt > BIT);
  end
endmodule // fbp_host_model

// ===== dv/fbp_checker.sv
// Port-level assertions for the flash boot and program controller
`timescale 1ns/1ps
module fbp_checker (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [7:0]  paddr, sci_baud_div, scan_rdata,
  input wire logic [31:0] pwdata,
  input wire logic        vpp_hv_pin, wdt_ovf, wdt_rst_out, sci_tx_en, sci_rx_en,
  input wire logic        boot_serial_tx_pin, boot_serial_tx_oe, erase_all_req,
  input wire logic        prog_pulse, erase_pulse, flash_rd_ok, irq_inhibit,
  input wire logic        boot_mode, jump_req,
  input wire logic [15:0] jump_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mode register write taken at this edge
  wire fl_wr = psel && penable && pready && pwrite && paddr == 8'h00;
  wire busy  = erase_all_req || prog_pulse || erase_pulse;
  wire blank = scan_rdata == 8'hFF;

  property p_rd_block; busy && $past(busy) |-> !flash_rd_ok; endproperty
  a_rd_block: assert property (p_rd_block)
    else $error("flash readable while busy");
  property p_irq; irq_inhibit == !flash_rd_ok; endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt block out of step");
  property p_wdt_hv; vpp_hv_pin [*6] |-> !wdt_rst_out; endproperty
  a_wdt_hv: assert property (p_wdt_hv)
    else $error("reset output under high voltage");
  property p_wdt_src; wdt_rst_out |-> $past(wdt_ovf); endproperty
  a_wdt_src: assert property (p_wdt_src)
    else $error("reset output without overflow");
  property p_p_on;
    $rose(prog_pulse) |-> $past(fl_wr && pwdata[0]) || $past(fl_wr && pwdata[0], 2);
  endproperty
  a_p_on: assert property (p_p_on)
    else $error("program pulse began without write");
  property p_p_off;
    $fell(prog_pulse) |-> $past(fl_wr && !pwdata[0], 2) || $past(fl_wr && !pwdata[0])
      || $past(wdt_ovf, 2) || $past(wdt_ovf);
  endproperty
  a_p_off: assert property (p_p_off)
    else $error("program pulse ended on its own");
  property p_p_hv; $rose(prog_pulse) |-> $past(vpp_hv_pin, 3); endproperty
  a_p_hv: assert property (p_p_hv)
    else $error("program pulse without high voltage");
  property p_boot_hold; $past(boot_mode) |-> boot_mode; endproperty
  a_boot_hold: assert property (p_boot_hold)
    else $error("boot latch dropped without reset");
  property p_erase;
    $rose(erase_all_req) |-> !$past(blank) || !$past(blank, 2) || !$past(blank, 3);
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase without programmed byte");
  property p_jump_addr; jump_req |=> jump_addr == 16'hF300; endproperty
  a_jump_addr: assert property (p_jump_addr)
    else $error("wrong user entry");
  property p_jump_ser;
    jump_req |-> ##2 (!sci_tx_en && !sci_rx_en && boot_serial_tx_pin && boot_serial_tx_oe
      && sci_baud_div == $past(sci_baud_div, 3));
  endproperty
  a_jump_ser: assert property (p_jump_ser)
    else $error("serial state wrong at jump");

  c_jump: cover property (jump_req);
  c_erase: cover property ($rose(erase_all_req));
  c_prog: cover property ($rose(prog_pulse));
  c_wdt: cover property (wdt_rst_out);
endmodule // fbp_checker

bind fbp_ctrl fbp_checker CHK (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .paddr,
  .sci_baud_div, .scan_rdata, .pwdata, .vpp_hv_pin, .wdt_ovf, .wdt_rst_out, .sci_tx_en,
  .sci_rx_en, .boot_serial_tx_pin, .boot_serial_tx_oe, .erase_all_req, .prog_pulse,
  .erase_pulse, .flash_rd_ok, .irq_inhibit, .boot_mode, .jump_req, .jump_addr);

// ===== dv/fbp_ctrl_tb_top.sv
// Self-checking bench for the flash boot and program controller
`timescale 1ns/1ps
`include "fbp_consts.vh"
module fbp_ctrl_tb_top;
  localparam int BIT = 80;
  localparam int BAUD_EXP = (9 * BIT) / (`FBP_BAUD_OVS * `FBP_LOW_BITS) - 1;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, scan_rdata = 8'hFF, cpu_fl_wdata = 8'h00, ecnt = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  logic        vpp_hv_pin = 1'b0, upper_mode_pin = 1'b0, wdt_ovf = 1'b0, send = 1'b0;
  logic        erase_done = 1'b0, cpu_fl_wr = 1'b0, err;
  logic [1:0]  mode_lo_pins = 2'h0;
  logic [16:0] cpu_fl_addr = 17'h0;
  wire  [31:0] prdata;
  wire  [16:0] scan_addr, fl_latch_addr;
  wire  [15:0] jump_addr;
  wire  [7:0]  sci_baud_div, fl_latch_data, blk_sel1, blk_sel2;
  wire         pready, pslverr, wdt_rst_out, boot_serial_rx_pin, boot_serial_tx_pin;
  wire         boot_serial_tx_oe, sci_tx_en, sci_rx_en, erase_all_req, prog_pulse;
  wire         erase_pulse, pverify, everify, prewrite_verify, flash_rd_ok, irq_inhibit;
  wire         boot_mode, user_prog_mode, jump_req;
  int          miscompares = 0, n_checks = 0, cyc = 0, n;
  logic [7:0]  mv [5] = '{8'h41, 8'h42, 8'h44, 8'h48, 8'h00};
  logic [4:0]  mx [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};

  always #20 pclk = ~pclk;

  fbp_host_model #(.BIT(BIT)) HOST (.pclk, .send_byte(send), .rx_line(boot_serial_rx_pin));

  fbp_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .vpp_hv_pin, .upper_mode_pin, .mode_lo_pins, .wdt_ovf, .wdt_rst_out,
    .boot_serial_rx_pin, .boot_serial_tx_pin, .boot_serial_tx_oe, .sci_tx_en, .sci_rx_en,
    .sci_baud_div, .scan_addr, .scan_rdata, .erase_all_req, .erase_done, .erase_fail(1'b0),
    .cpu_fl_wr, .cpu_fl_addr, .cpu_fl_wdata, .fl_latch_addr, .fl_latch_data, .prog_pulse,
    .erase_pulse, .pverify, .everify, .prewrite_verify, .blk_sel1, .blk_sel2, .flash_rd_ok,
    .irq_inhibit, .boot_mode, .user_prog_mode, .jump_req, .jump_addr);

  // Flash stand-in: one programmed byte near the bottom, erase_done rises 21 cycles after the request
  always @(posedge pclk) begin
    scan_rdata <= (scan_addr == 17'h00003) ? 8'h00 : 8'hFF;
    ecnt <= erase_all_req ? ecnt + 8'h01 : 8'h00;
    erase_done <= ecnt == 8'h14;
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      miscompares++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) miscompares++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pins_rst(input logic v, input logic u, input logic [1:0] m);
    presetn <= 1'b0;
    vpp_hv_pin <= v;
    upper_mode_pin <= u;
    mode_lo_pins <= m;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Strap capture lands at edge three, mode outputs one edge later
    repeat (6) @(posedge pclk);
  endtask

  task automatic wdt_pulse;
    wdt_ovf <= 1'b1;
    @(posedge pclk);
    wdt_ovf <= 1'b0;
    @(posedge pclk);
  endtask

  // Measurement may only start once the ready time has passed
  task automatic host_byte;
    repeat (110) @(posedge pclk);
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    for (n = 0; n < 3000 && sci_rx_en !== 1'b1; n++) @(posedge pclk);
  endtask

  initial begin
    pins_rst(1'b1, 1'b1, 2'h3);
    chk(boot_mode, 1'b1);
    host_byte();
    chk({sci_tx_en, sci_baud_div}, {1'b1, 8'(BAUD_EXP)});
    for (n = 0; n < 200 && erase_all_req !== 1'b1; n++) @(posedge pclk);
    @(posedge pclk);
    chk({erase_all_req, flash_rd_ok, irq_inhibit}, 3'b101);
    for (n = 0; n < 100 && erase_all_req !== 1'b0; n++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk({flash_rd_ok, irq_inhibit}, 2'b10);
    upper_mode_pin <= 1'b0;
    apb(1'b1, `FBP_OFS_BOOTCTRL, 32'h3);
    repeat (4) @(posedge pclk);
    chk({sci_tx_en, sci_rx_en, sci_baud_div}, {2'b00, 8'(BAUD_EXP)});
    chk({boot_serial_tx_pin, boot_serial_tx_oe, jump_addr}, {2'b11, 16'hF300});
    chk(boot_mode, 1'b1);
    wdt_pulse();
    chk(boot_mode, 1'b1);
    chk(wdt_rst_out, 1'b0);
    host_byte();
    chk(sci_rx_en, 1'b1);
    $display("boot test done");
    pins_rst(1'b1, 1'b0, 2'h1);
    chk({boot_mode, user_prog_mode}, 2'b01);
    apb(1'b0, `FBP_OFS_BAUD, 32'h0);
    chk(q, 32'hFF);
    apb(1'b0, 8'h30, 32'h0);
    chk({err, q}, {1'b1, 32'h0});
    apb(1'b1, `FBP_OFS_FLMODE, 32'h1);
    repeat (2) @(posedge pclk);
    chk(prog_pulse, 1'b0);
    apb(1'b1, `FBP_OFS_FLMODE, 32'h40);
    repeat (130) @(posedge pclk);
    apb(1'b1, `FBP_OFS_BLKSEL1, 32'h5A);
    apb(1'b1, `FBP_OFS_BLKSEL2, 32'hA5);
    cpu_fl_addr <= 17'h1ABCD;
    cpu_fl_wdata <= 8'h3C;
    cpu_fl_wr <= 1'b1;
    @(posedge pclk);
    cpu_fl_wr <= 1'b0;
    @(posedge pclk);
    chk({blk_sel1, blk_sel2, fl_latch_data}, 24'h5AA53C);
    apb(1'b0, `FBP_OFS_LATADDR, 32'h0);
    chk(q, 32'h1ABCD);
    // Retries double the pulse; a watchdog overflow cuts a runaway pulse, here with the reset output disabled
    for (int k = 4; k <= 16; k = k * 2) begin
      apb(1'b1, `FBP_OFS_FLMODE, 32'h41);
      repeat (k) @(posedge pclk);
      chk({prog_pulse, flash_rd_ok}, 2'b10);
      apb(1'b1, `FBP_OFS_FLMODE, 32'h40);
      repeat (2) @(posedge pclk);
      chk(prog_pulse, 1'b0);
    end
    apb(1'b1, `FBP_OFS_FLMODE, 32'h41);
    wdt_pulse();
    @(posedge pclk);
    chk(prog_pulse, 1'b0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `FBP_OFS_FLMODE, {24'h0, mv[i]});
      repeat (2) @(posedge pclk);
      chk({prog_pulse, erase_pulse, pverify, everify, prewrite_verify, flash_rd_ok},
          {mx[i], !(mx[i][4] | mx[i][3])});
    end
    wdt_pulse();
    chk(wdt_rst_out, 1'b0);
    vpp_hv_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    // Reset output enabled only once high voltage is gone
    apb(1'b1, `FBP_OFS_BOOTCTRL, 32'h2);
    wdt_pulse();
    chk(wdt_rst_out, 1'b1);
    $display("user mode test done");
    results();
  end
endmodule // fbp_ctrl_tb_top
